// ===== rtl/mnab_branch_mux.sv
// Branch test multiplexer over machine state
`timescale 1ns/1ps
`default_nettype none
module mnab_branch_mux
    import mnab_pkg::*;
(
    input  wire logic [CODE_W-1:0] code_i,
    input  wire logic [3:0]        shifter_reg_i,
    input  wire logic [15:0]       instr_holding_reg_i,
    input  wire logic [1:0]        guard_top_i,
    input  wire logic              status_mode_i,
    input  wire logic [15:0]       result_i,
    input  wire logic              alu_carry_i,
    input  wire logic              dst_mode0_i,
    input  wire logic              src_mode0_i,
    input  wire logic              byte_op_i,
    input  wire logic              no_overlap_i,
    input  wire logic              service_i,
    input  wire logic              move_instr_i,
    input  wire logic              flpt_dr7_i,
    input  wire logic              cnt_ones_i,
    output logic      [PTR_W-1:0]  mux_o
);
    logic zero_result_test;

    assign zero_result_test = (result_i[14:0] == 15'h0000);

    // Every test is right-justified; codes without a test give zeros
    always_comb begin
        mux_o = 9'h000;
        case (code_i)
            BR_CASE:   mux_o = {5'h00, shifter_reg_i};
            BR_DBL_OP: mux_o = {5'h00, instr_holding_reg_i[15:12]};
            BR_SGL_OP: mux_o = {5'h00, instr_holding_reg_i[9:6]};
            BR_DSTMOD: mux_o = {4'h0, 1'b0, move_instr_i | flpt_dr7_i,
                                instr_holding_reg_i[5:3]};
            BR_MODES:  mux_o = {6'h00, dst_mode0_i, src_mode0_i, byte_op_i};
            BR_GUARD:  mux_o = {7'h00, guard_top_i};
            BR_MULSTP: mux_o = {6'h00, shifter_reg_i[1:0], cnt_ones_i};
            BR_ZERO:   mux_o = {7'h00, zero_result_test, result_i[15]};
            BR_JUMP:   mux_o = {7'h00, instr_holding_reg_i[11], status_mode_i};
            BR_ASHSTP: mux_o = {7'h00, cnt_ones_i, alu_carry_i};
            BR_SERV:   mux_o = {7'h00, no_overlap_i, service_i};
            BR_COUNT:  mux_o = {8'h00, cnt_ones_i};
            default:   mux_o = 9'h000;
        endcase
    end
endmodule : mnab_branch_mux
`default_nettype wire

// ===== rtl/mnab_loop_counter.sv
// Eight-bit loop counter with test flag, load and increment
`timescale 1ns/1ps
`default_nettype none
module mnab_loop_counter
    import mnab_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             inc_i,
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] load_val_i,
    output logic      [CNT_W-1:0] count_o,
    output logic                  all_ones_o
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // Software load beats a same-cycle increment
    always_comb begin
        nxt_cnt = cnt_ff;
        if (load_i) begin
            nxt_cnt = load_val_i;
        end else if (inc_i) begin
            nxt_cnt = cnt_ff + 8'h01; // Wraps after the exit test
        end
    end

    // Counter register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_ff <= CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign count_o    = cnt_ff;
    assign all_ones_o = &cnt_ff; // Tested before the increment lands
endmodule : mnab_loop_counter
`default_nettype wire

// ===== rtl/mnab_pkg.sv
// Shared constants for the next-microaddress branch block
package mnab_pkg;
    // ****************************************
    // Microword field layout
    // ****************************************
    localparam int PTR_W   = 9;
    localparam int PTR_LSB = 0;
    localparam int PTR_MSB = 8;
    localparam int CODE_W  = 5;
    localparam int CODE_LSB = 9;
    localparam int CODE_MSB = 13;
    localparam int UW_W    = 14;
    localparam int CNT_W   = 8;

    // ****************************************
    // Branch-select codes (octal code noted at right)
    // ****************************************
    localparam logic [4:0] BR_CASE   = 5'h00; // 00
    localparam logic [4:0] BR_DBL_OP = 5'h01; // 01
    localparam logic [4:0] BR_SGL_OP = 5'h04; // 04
    localparam logic [4:0] BR_DSTMOD = 5'h05; // 05
    localparam logic [4:0] BR_MODES  = 5'h09; // 11
    localparam logic [4:0] BR_GUARD  = 5'h0A; // 12
    localparam logic [4:0] BR_MULSTP = 5'h0B; // 13
    localparam logic [4:0] BR_ZERO   = 5'h0D; // 15
    localparam logic [4:0] BR_JUMP   = 5'h0E; // 16
    localparam logic [4:0] BR_ASHSTP = 5'h0F; // 17
    localparam logic [4:0] BR_SERV   = 5'h10; // 20
    localparam logic [4:0] BR_COUNT  = 5'h15; // 25
    localparam logic [4:0] BR_NULL   = 5'h18; // 30

    // ****************************************
    // Reset values and register map
    // ****************************************
    localparam logic [13:0] UW_RST  = {BR_NULL, 9'h000};
    localparam logic [7:0]  CNT_RST = 8'h00;
    localparam logic [11:0] OFS_COUNT  = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_UWORD  = 12'h008;
    localparam int ST_ONES_BIT = 16;
endpackage : mnab_pkg

// ===== rtl/mnab_top.sv
// Next-microaddress formation with microword register and APB access
//
// Functional notes
// - Pointer field sits in microword bits 8:0
// - Branch-select field sits in bits 13:9
// - Next address is pointer OR mux
// - Unconditional branch passes pointer unchanged
// - Pointer ones mask their tested bits
// - Regular codes only OR; active codes change state
// - Code 25 tests all-ones then increments counter
// - Test uses state clocked last microcycle
// - Address drives store combinationally, unregistered
// - Code 15 tests result zero and sign
// - Code 30 is the null default
// - Active-high tests, right-justified widths
// - Code 00 ORs shifter bits 3:0
// - Code 01 ORs instruction bits 15:12
// - Code 04 ORs instruction bits 9:6
// - Code 12 ORs guard bits 3:2
// - Code 13 multiply step, increments counter
// - Code 17 counter flag and carry, increments
// - Code 16 jump kind and mode
// - Code 11 tests modes zero and byte
// - Code 20 tests overlap and service
// - Code 05 tests move/flpt and mode
// - Code 30 changes no machine state
`timescale 1ns/1ps
`default_nettype none
module mnab_top
    import mnab_pkg::*;
(
    input  wire logic        MCLK_I,
    input  wire logic        NRST_I,
    // APB slave
    input  wire logic [11:0] PADDR_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [31:0] PWDATA_I,
    input  wire logic [3:0]  PSTRB_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Microcycle timing and control store
    input  wire logic        THIRD_CLOCK_PULSE_I,
    input  wire logic [13:0] CS_DATA_I,
    output logic      [8:0]  NEXT_MICRO_ADDR_O,
    // Machine state under test
    input  wire logic [3:0]  SHIFTER_REG_I,
    input  wire logic [15:0] INSTR_HOLDING_REG_I,
    input  wire logic [1:0]  GUARD_BITS_REG_I,
    input  wire logic        PROC_STATUS_MODE_I,
    input  wire logic [15:0] RESULT_LATCH_I,
    input  wire logic        ALU_CARRY_I,
    input  wire logic        DST_MODE0_I,
    input  wire logic        SRC_MODE0_I,
    input  wire logic        BYTE_OP_I,
    input  wire logic        NO_OVERLAP_I,
    input  wire logic        SERVICE_I,
    input  wire logic        MOVE_INSTR_I,
    input  wire logic        FLPT_DR7_I
);
    // ****************************************
    // Declarations
    // ****************************************
    logic [UW_W-1:0]   uword_ff;
    logic [PTR_W-1:0]  next_pointer_field;
    logic [CODE_W-1:0] branch_select_field;
    logic [PTR_W-1:0]  branch_test_mux;
    logic [PTR_W-1:0]  next_micro_address;
    logic [PTR_W-1:0]  last_addr_ff;
    logic [CNT_W-1:0]  loop_counter;
    logic              cnt_ones;
    logic              cnt_inc;
    logic              cnt_load;
    logic              counting_code;
    logic              apb_setup;
    logic              apb_done;
    logic              apb_wr;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;
    logic [31:0]       nxt_prdata;
    logic              nxt_pslverr;

    // ****************************************
    // Microword register
    // ****************************************

    // Loaded on every third pulse from the addressed store word
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            uword_ff <= UW_RST;
        end else if (THIRD_CLOCK_PULSE_I) begin
            uword_ff <= CS_DATA_I;
        end
    end

    // Field split of the live microword
    assign next_pointer_field  = uword_ff[PTR_MSB:PTR_LSB];
    assign branch_select_field = uword_ff[CODE_MSB:CODE_LSB];

    // ****************************************
    // Branch test and address formation
    // ****************************************

    // Machine state is read live; the datapath holds it through the cycle
    mnab_branch_mux u_mux (
        .code_i              (branch_select_field),
        .shifter_reg_i       (SHIFTER_REG_I),
        .instr_holding_reg_i (INSTR_HOLDING_REG_I),
        .guard_top_i         (GUARD_BITS_REG_I),
        .status_mode_i       (PROC_STATUS_MODE_I),
        .result_i            (RESULT_LATCH_I),
        .alu_carry_i         (ALU_CARRY_I),
        .dst_mode0_i         (DST_MODE0_I),
        .src_mode0_i         (SRC_MODE0_I),
        .byte_op_i           (BYTE_OP_I),
        .no_overlap_i        (NO_OVERLAP_I),
        .service_i           (SERVICE_I),
        .move_instr_i        (MOVE_INSTR_I),
        .flpt_dr7_i          (FLPT_DR7_I),
        .cnt_ones_i          (cnt_ones),
        .mux_o               (branch_test_mux)
    );

    // Per-bit OR; a one in the pointer hides that test
    genvar gi;
    generate
        for (gi = 0; gi < PTR_W; gi++) begin : g_or
            assign next_micro_address[gi] =
                next_pointer_field[gi] | branch_test_mux[gi];
        end
    endgenerate

    // No register here: a retimed address would cost a whole microcycle
    assign NEXT_MICRO_ADDR_O = next_micro_address;

    // Snapshot of the address taken, for software visibility
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            last_addr_ff <= 9'h000;
        end else if (THIRD_CLOCK_PULSE_I) begin
            last_addr_ff <= next_micro_address;
        end
    end

    // ****************************************
    // Loop counter
    // ****************************************

    // Only active counting codes touch state; null and regular do not
    assign counting_code = (branch_select_field == BR_COUNT)
                         | (branch_select_field == BR_MULSTP)
                         | (branch_select_field == BR_ASHSTP);
    assign cnt_inc  = THIRD_CLOCK_PULSE_I & counting_code;
    assign cnt_load = apb_wr & (PADDR_I == OFS_COUNT) & PSTRB_I[0];

    mnab_loop_counter u_cnt (
        .clk_i      (MCLK_I),
        .rst_n_i    (NRST_I),
        .inc_i      (cnt_inc),
        .load_i     (cnt_load),
        .load_val_i (PWDATA_I[7:0]),
        .count_o    (loop_counter),
        .all_ones_o (cnt_ones)
    );

    // ****************************************
    // APB slave
    // ****************************************

    // One wait state: ready follows the first access cycle
    assign apb_setup = PSEL_I & PENABLE_I & ~pready_ff;
    assign apb_done  = PSEL_I & PENABLE_I & pready_ff;
    assign apb_wr    = apb_done & PWRITE_I;

    // Ready pulse
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            pready_ff <= 1'b0;
        end else begin
            pready_ff <= apb_setup;
        end
    end

    // Read mux and error decode; unmapped or read-only writes flag error
    always_comb begin
        nxt_prdata  = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        case (PADDR_I)
            OFS_COUNT: begin
                nxt_prdata = {24'h00_0000, loop_counter};
            end
            OFS_STATUS: begin
                nxt_prdata = {15'h0000, cnt_ones, 2'b00,
                              branch_select_field, last_addr_ff};
                nxt_pslverr = PWRITE_I;
            end
            OFS_UWORD: begin
                nxt_prdata = {18'h0_0000, uword_ff};
                nxt_pslverr = PWRITE_I;
            end
            default: begin
                nxt_pslverr = 1'b1;
            end
        endcase
        if (PWRITE_I) begin
            nxt_prdata = 32'h0000_0000;
        end
    end

    // Read data and error are held only for the ready cycle
    always_ff @(posedge MCLK_I) begin
        if (!NRST_I) begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end else if (apb_setup) begin
            prdata_ff  <= nxt_prdata;
            pslverr_ff <= nxt_pslverr;
        end else begin
            prdata_ff  <= 32'h0000_0000;
            pslverr_ff <= 1'b0;
        end
    end

    assign PRDATA_O  = prdata_ff;
    assign PREADY_O  = pready_ff;
    assign PSLVERR_O = pslverr_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!NRST_I);

    property p_null_pass;
        branch_select_field == BR_NULL |->
            NEXT_MICRO_ADDR_O == uword_ff[8:0];
    endproperty
    a_null_pass: assert property (p_null_pass)
        else $error("null code altered the address");

    property p_mask;
        (NEXT_MICRO_ADDR_O & uword_ff[8:0]) == uword_ff[8:0];
    endproperty
    a_mask: assert property (p_mask)
        else $error("pointer one bit cleared");

    property p_case;
        branch_select_field == BR_CASE |->
            NEXT_MICRO_ADDR_O == (uword_ff[8:0] | {5'h00, SHIFTER_REG_I});
    endproperty
    a_case: assert property (p_case)
        else $error("case dispatch wrong");

    property p_high_bits;
        branch_select_field != BR_DSTMOD |->
            NEXT_MICRO_ADDR_O[8:4] == uword_ff[8:4];
    endproperty
    a_high_bits: assert property (p_high_bits)
        else $error("high address bits disturbed");

    property p_count_inc;
        THIRD_CLOCK_PULSE_I && branch_select_field == BR_COUNT && !cnt_load
            |=> loop_counter == $past(loop_counter) + 8'h01;
    endproperty
    a_count_inc: assert property (p_count_inc)
        else $error("count code did not increment");

    property p_count_exit;
        branch_select_field == BR_COUNT && loop_counter == 8'hFF
            |-> NEXT_MICRO_ADDR_O[0];
    endproperty
    a_count_exit: assert property (p_count_exit)
        else $error("loop exit bit missing");

    property p_null_state;
        branch_select_field == BR_NULL && !cnt_load
            |=> $stable(loop_counter);
    endproperty
    a_null_state: assert property (p_null_state)
        else $error("null code changed counter");

    property p_zero_test;
        branch_select_field == BR_ZERO && RESULT_LATCH_I[14:0] == 15'h0000
            |-> NEXT_MICRO_ADDR_O[1];
    endproperty
    a_zero_test: assert property (p_zero_test)
        else $error("zero result not flagged");

    property p_uword_load;
        THIRD_CLOCK_PULSE_I |=> uword_ff == $past(CS_DATA_I);
    endproperty
    a_uword_load: assert property (p_uword_load)
        else $error("microword not loaded at pulse");

    property p_uword_hold;
        !THIRD_CLOCK_PULSE_I |=> $stable(branch_select_field);
    endproperty
    a_uword_hold: assert property (p_uword_hold)
        else $error("branch field moved mid cycle");

    property p_apb_ready;
        PSEL_I && PENABLE_I && !PREADY_O |=> PREADY_O;
    endproperty
    a_apb_ready: assert property (p_apb_ready)
        else $error("apb ready late");

    // Dispatch and test codes checked against the microword itself; counting codes against the past count
    property p_dbl_dispatch;
        branch_select_field == BR_DBL_OP |->
            NEXT_MICRO_ADDR_O == (uword_ff[8:0] | {5'h00, INSTR_HOLDING_REG_I[15:12]});
    endproperty
    a_dbl_dispatch: assert property (p_dbl_dispatch)
        else $error("double operand dispatch wrong");

    property p_sgl_dispatch;
        branch_select_field == BR_SGL_OP |->
            NEXT_MICRO_ADDR_O == (uword_ff[8:0] | {5'h00, INSTR_HOLDING_REG_I[9:6]});
    endproperty
    a_sgl_dispatch: assert property (p_sgl_dispatch)
        else $error("single operand dispatch wrong");

    property p_guard_test;
        branch_select_field == BR_GUARD |->
            NEXT_MICRO_ADDR_O == (uword_ff[8:0] | {7'h00, GUARD_BITS_REG_I});
    endproperty
    a_guard_test: assert property (p_guard_test)
        else $error("guard test wrong");

    property p_sign_test;
        branch_select_field == BR_ZERO |->
            NEXT_MICRO_ADDR_O[0] == (uword_ff[0] | RESULT_LATCH_I[15]);
    endproperty
    a_sign_test: assert property (p_sign_test)
        else $error("sign bit not tested");

    property p_mulstep_inc;
        THIRD_CLOCK_PULSE_I && branch_select_field == BR_MULSTP && !cnt_load
            |=> loop_counter == $past(loop_counter) + 8'h01;
    endproperty
    a_mulstep_inc: assert property (p_mulstep_inc)
        else $error("multiply step did not increment");

    property p_ashstep_inc;
        THIRD_CLOCK_PULSE_I && branch_select_field == BR_ASHSTP && !cnt_load
            |=> loop_counter == $past(loop_counter) + 8'h01;
    endproperty
    a_ashstep_inc: assert property (p_ashstep_inc)
        else $error("shift step did not increment");

    property p_regular_state;
        THIRD_CLOCK_PULSE_I && !cnt_load && branch_select_field != BR_COUNT
            && branch_select_field != BR_MULSTP && branch_select_field != BR_ASHSTP
            |=> $stable(loop_counter);
    endproperty
    a_regular_state: assert property (p_regular_state)
        else $error("regular code changed counter");
endmodule : mnab_top
`default_nettype wire

// ===== tb/mnab_cs_model.sv
// Control store model read at the formed next microaddress
`timescale 1ns/1ps
`default_nettype none
module mnab_cs_model
    import mnab_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             wr_i,
    input  wire logic [PTR_W-1:0] wr_addr_i,
    input  wire logic [UW_W-1:0]  wr_data_i,
    input  wire logic [PTR_W-1:0] addr_i,
    output logic      [UW_W-1:0]  data_o
);
    // ****************************************
    // Store array
    // ****************************************
    logic [UW_W-1:0] mem_ff [0:511];

    // Unloaded words hold the null microword
    initial begin
        for (int i = 0; i < 512; i++) begin
            mem_ff[i] = UW_RST;
        end
    end

    // Bench loads words one at a time
    always @(posedge clk_i) begin
        if (wr_i) begin
            mem_ff[wr_addr_i] <= wr_data_i;
        end
    end

    // Unlatched read: any glitch on the address shows at once, as in a real store
    assign data_o = mem_ff[addr_i];
endmodule : mnab_cs_model
`default_nettype wire

// ===== tb/mnab_top_tb.sv
// Self-checking bench for next-microaddress formation
`timescale 1ns/1ps
`default_nettype none
module mnab_top_tb;
    import mnab_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic        mclk, nrst_n, psel, penable, pwrite, pulse, cs_wr, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] cs_wd, cs_data;
    logic [8:0]  cs_wa, naddr;
    logic [3:0]  shf;
    logic [15:0] instr, res;
    logic [1:0]  guard;
    logic        smode, carry, dst0, src0, byte_op, novl, serv, movi, fdr7, er, ones_exp;
    int          fails, n_checks, cyc;
    logic [4:0]  codes [11] = '{BR_CASE, BR_DBL_OP, 5'h02, BR_SGL_OP, BR_DSTMOD, BR_MODES,
                                BR_GUARD, BR_ZERO, BR_JUMP, BR_SERV, BR_NULL};
    logic [4:0]  inc_codes [3] = '{BR_COUNT, BR_MULSTP, BR_ASHSTP};

    mnab_top dut (.MCLK_I(mclk), .NRST_I(nrst_n), .PADDR_I(paddr), .PSEL_I(psel),
        .PENABLE_I(penable), .PWRITE_I(pwrite), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .THIRD_CLOCK_PULSE_I(pulse), .CS_DATA_I(cs_data), .NEXT_MICRO_ADDR_O(naddr),
        .SHIFTER_REG_I(shf), .INSTR_HOLDING_REG_I(instr), .GUARD_BITS_REG_I(guard),
        .PROC_STATUS_MODE_I(smode), .RESULT_LATCH_I(res), .ALU_CARRY_I(carry),
        .DST_MODE0_I(dst0), .SRC_MODE0_I(src0), .BYTE_OP_I(byte_op),
        .NO_OVERLAP_I(novl), .SERVICE_I(serv), .MOVE_INSTR_I(movi), .FLPT_DR7_I(fdr7));

    mnab_cs_model u_cs (.clk_i(mclk), .wr_i(cs_wr), .wr_addr_i(cs_wa), .wr_data_i(cs_wd),
        .addr_i(naddr), .data_o(cs_data));

    // ****************************************
    // Clock, timeout and shared tasks
    // ****************************************
    always #2 mclk = ~mclk;

    // Whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Ready sampled before the edge's updates land, so no race with the slave flops
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One pattern word spreads over every tested state input
    task automatic set_state(input logic [15:0] v);
        shf     <= v[3:0];
        instr   <= v;
        guard   <= v[5:4];
        smode   <= v[6];
        res     <= v[7] ? (v & 16'h8000) : v;
        carry   <= v[8];
        dst0    <= v[9];
        src0    <= v[10];
        byte_op <= v[11];
        novl    <= v[12];
        serv    <= v[13];
        movi    <= v[14];
        fdr7    <= v[15];
    endtask : set_state

    function automatic logic [8:0] exp_mux(input logic [4:0] c);
        case (c)
            BR_CASE:   return {5'h00, shf};
            BR_DBL_OP: return {5'h00, instr[15:12]};
            BR_SGL_OP: return {5'h00, instr[9:6]};
            BR_DSTMOD: return {5'h00, movi | fdr7, instr[5:3]};
            BR_MODES:  return {6'h00, dst0, src0, byte_op};
            BR_GUARD:  return {7'h00, guard};
            BR_MULSTP: return {6'h00, shf[1:0], ones_exp};
            BR_ZERO:   return {7'h00, res[14:0] == 15'h0000, res[15]};
            BR_JUMP:   return {7'h00, instr[11], smode};
            BR_ASHSTP: return {7'h00, ones_exp, carry};
            BR_SERV:   return {7'h00, novl, serv};
            BR_COUNT:  return {8'h00, ones_exp};
            default:   return 9'h000;
        endcase
    endfunction : exp_mux

    // Store a word at the current address, pulse, then judge the new address
    task automatic exec(input logic [4:0] c, input logic [8:0] p);
        @(posedge mclk);
        cs_wr <= 1'b1;
        cs_wa <= naddr;
        cs_wd <= {c, p};
        @(posedge mclk);
        cs_wr <= 1'b0;
        pulse <= 1'b1;
        @(posedge mclk);
        pulse <= 1'b0;
        #1 chk({23'h00_0000, naddr}, {23'h00_0000, p | exp_mux(c)});
        // Return on an edge so that callers drive state at the rising edge
        @(posedge mclk);
    endtask : exec

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        #1 chk({23'h00_0000, naddr}, 32'h0000_0000);
        apb(1'b0, OFS_STATUS, 32'h0000_0000);
        chk({24'h00_0000, rd[16:9]}, {27'h000_0000, BR_NULL});
        apb(1'b0, OFS_UWORD, 32'h0000_0000);
        chk(rd, {18'h0_0000, UW_RST});
        $display("test reset done");
    endtask : t_reset

    task automatic t_codes();
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 11; i++) begin
                set_state(k ? 16'h5A3C : 16'hA5C3);
                exec(codes[i], k ? 9'h1F5 : 9'h100);
            end
        end
        $display("test codes done");
    endtask : t_codes

    task automatic t_counter();
        for (int i = 0; i < 3; i++) begin
            for (int k = 0; k < 2; k++) begin
                exec(BR_NULL, 9'h000);
                apb(1'b1, OFS_COUNT, k ? 32'h0000_00FF : 32'h0000_00FE);
                ones_exp = k[0];
                exec(inc_codes[i], 9'h040);
                ones_exp = 1'b0;
                exec(BR_NULL, 9'h080);
                exec(BR_NULL, 9'h0C0);
                apb(1'b0, OFS_COUNT, 32'h0000_0000);
                chk(rd & 32'h0000_00FF, k ? 32'h0000_0000 : 32'h0000_00FF);
            end
        end
        $display("test counter done");
    endtask : t_counter

    task automatic t_regs();
        set_state(16'h0000);
        exec(BR_CASE, 9'h100);
        @(posedge mclk);
        shf <= 4'h9;
        #1 chk({23'h00_0000, naddr}, 32'h0000_0109);
        apb(1'b0, OFS_UWORD, 32'h0000_0000);
        chk(rd, {18'h0_0000, BR_CASE, 9'h100});
        apb(1'b0, 12'h00C, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        apb(1'b1, OFS_STATUS, 32'h0000_0000);
        chk({31'h0000_0000, er}, 32'h0000_0001);
        $display("test regs done");
    endtask : t_regs

    initial begin
        mclk = 1'b0;
        nrst_n = 1'b0;
        {psel, penable, pwrite, pulse, cs_wr, ones_exp} = '0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        cs_wa = 9'h000;
        cs_wd = UW_RST;
        fails = 0;
        n_checks = 0;
        cyc = 0;
        set_state(16'h0000);
        repeat (8) @(posedge mclk);
        nrst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_codes();
        t_counter();
        t_regs();
        report_and_stop();
    end
endmodule : mnab_top_tb
`default_nettype wire
